// ---- tsrc_cfg.svh ----
`ifndef TSRC_CFG_SVH
`define TSRC_CFG_SVH
// result length codes
`define TSRC_LEN_8 3'h0
`define TSRC_LEN_16 3'h1
`define TSRC_LEN_24 3'h2
`define TSRC_LEN_32 3'h3
`define TSRC_LEN_40 3'h4
`define TSRC_LEN_DEFAULT 3'h4
// coarse range codes
`define TSRC_RNG_RSVD 2'h0
`define TSRC_RNG_18 2'h1
`define TSRC_RNG_27 2'h2
`define TSRC_RNG_34 2'h3
// counter widths per range
`define TSRC_W_18 18
`define TSRC_W_27 27
`define TSRC_W_34 34
// pipeline depth from buffer to shift register, result-clock cycles
`define TSRC_PIPE_CYC 3'h5
// overhead bits per frame: tag plus two strobe-high bits
`define TSRC_FRAME_OVH 3
// minimum repeat capture time in ns and its cycle count at 125 MHz
`define TSRC_TREP_NS 5
`define TSRC_CLK_MHZ 125
`define TSRC_TREP_CYC (((`TSRC_TREP_NS*`TSRC_CLK_MHZ)+999)/1000)
// alarm trip temperature in degrees C
`define TSRC_OT_TRIP_C 141
`define TSRC_THERMAL_MONITOR_ENABLE_RST 1'b1
`endif

// ---- tsrc_pkg.sv ----
package tsrc_pkg;
    // one captured time stamp with its edge polarity
    typedef struct packed {
        logic [33:0] stamp;
        logic pol;
    } tsrc_stamp_t;
    // serialiser states
    typedef enum logic [2:0] {
        TSRC_S_IDLE = 3'b001,
        TSRC_S_SHIFT = 3'b010,
        TSRC_S_HIGH = 3'b100
    } tsrc_state_t;
endpackage

// ---- tsrc_core.sv ----
`timescale 1ns/100ps
`include "tsrc_cfg.svh"
// Notes on behaviour
// - five cycles to load, then length plus three
// - free-running load may add one frame
// - captures closer than 5 ns are ignored
// - load pulse samples current sync stamp
// - newer sync gives negative result
// - results corrected by stored calibration
// - one calibration value per polarity pair, four per channel
// - alarm pin asserts at 141 C
// - alarm sets sticky thermal alarm flag
// - alarm forces power down, logic runs
// - monitor enable, default on
// - range field selects counter width
// - counter advances each core clock
// - events and sync share one counter
// - valid event edge captures counter
// - result is event minus sync
// - per-channel data, common result clock
// - strobe low, tag, lsb first, two high
// - length code picks 8 to 40 bits
module tsrc_core
    import tsrc_pkg::*;
#(
    parameter int NCH = 4,
    parameter int TREP = `TSRC_TREP_CYC
)(
    input wire logic core_clk, // counter clock
    input wire logic nrst, // sync reset, active low
    input wire logic rclk, // result clock
    input wire logic rNrst, // result-domain reset, active low
    input wire logic syncIn, // sync channel input pin
    input wire logic syncPol, // sync edge: 0 rising, 1 falling
    input wire logic [NCH-1:0] eventIn, // event input pins
    input wire logic [NCH-1:0] eventPol, // event edge per channel
    input wire logic [1:0] coarseRangeSel, // {hi,lo} range select
    input wire logic [2:0] resultLength, // result length code
    input wire logic [NCH*4*40-1:0] calValues, // calibration, 4 per ch
    input wire logic [7:0] dieTemp, // die temperature, degrees C
    input wire logic thermal_monitor_enable, // monitor on when 1
    input wire logic thermal_alarm_clear, // clears alarm flag
    output logic thermal_alarm_flag, // sticky alarm flag
    output logic thermal_alarm_pin_o, // pin output value, held 0
    output logic thermal_alarm_pin_oe_n, // low while pulling pin low
    output logic powerDown, // automatic power down
    output logic [NCH-1:0] rStrobe, // per channel strobe
    output logic [NCH-1:0] rData // per channel serial data
);
    // input synchronisers
    logic [NCH:0] pinS1_q, pinS2_q, pinS3_q;
    logic [33:0] cnt_q; // shared coarse counter
    logic [33:0] cntMask; // width mask from range select
    logic [33:0] syncStamp_q; // latest sync stamp
    logic syncPolLat_q; // polarity of latest sync
    logic [5:0] len; // result data length in bits
    logic [7:0] tempS1_q, tempS2_q;
    logic enS1_q, enS2_q, clrS1_q, clrS2_q;

    // range select to counter mask
    assign cntMask = (coarseRangeSel == `TSRC_RNG_18) ? 34'h000_03FFFF :
                     (coarseRangeSel == `TSRC_RNG_27) ? 34'h0_07FFFFFF :
                     (coarseRangeSel == `TSRC_RNG_34) ? 34'h3_FFFFFFFF :
                     34'h0; // reserved holds counter at zero
    assign len = (resultLength == `TSRC_LEN_8) ? 6'd8 :
                 (resultLength == `TSRC_LEN_16) ? 6'd16 :
                 (resultLength == `TSRC_LEN_24) ? 6'd24 :
                 (resultLength == `TSRC_LEN_32) ? 6'd32 : 6'd40;

    // two-stage sync of pins, third stage for edge detect
    always_ff @(posedge core_clk)
    begin
        pinS1_q <= {syncIn, eventIn};
        pinS2_q <= pinS1_q;
        pinS3_q <= pinS2_q;
        tempS1_q <= dieTemp;
        tempS2_q <= tempS1_q;
        enS1_q <= thermal_monitor_enable;
        enS2_q <= enS1_q;
        clrS1_q <= thermal_alarm_clear;
        clrS2_q <= clrS1_q;
    end

    // one shared counter, one count per clock
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            cnt_q <= 34'h0;
        else
            cnt_q <= (cnt_q + 34'h1) & cntMask;
    end

    // thermal alarm: set wins over clear
    logic otHot;
    assign otHot = enS2_q && (tempS2_q >= 8'(`TSRC_OT_TRIP_C));
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            thermal_alarm_flag <= 1'b0;
        else if (otHot)
            thermal_alarm_flag <= 1'b1;
        else if (clrS2_q)
            thermal_alarm_flag <= 1'b0;
    end
    assign thermal_alarm_pin_o = 1'b0;
    assign thermal_alarm_pin_oe_n = !otHot; // open-drain pull
    assign powerDown = thermal_alarm_flag; // digital keeps running

    // sync channel edge and stamp
    logic syncEdge;
    logic [31:0] syncGap_q;
    assign syncEdge = (pinS2_q[NCH] ^ pinS3_q[NCH]) &&
                      (pinS2_q[NCH] != syncPol) && (syncGap_q >= TREP);
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            syncStamp_q <= 34'h0;
            syncPolLat_q <= 1'b0;
            syncGap_q <= 32'h0;
        end
        else if (syncEdge)
        begin
            syncStamp_q <= cnt_q;
            syncPolLat_q <= syncPol;
            syncGap_q <= 32'h1;
        end
        else if (syncGap_q < TREP)
            syncGap_q <= syncGap_q + 32'h1;
    end

    // sync stamp to result domain: toggle handshake
    logic syncTgl_q;
    logic [2:0] syncTglR_q;
    logic [34:0] syncHold_q; // stable word sampled by rclk
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            syncTgl_q <= 1'b0;
            syncHold_q <= 35'h0;
        end
        else if (syncEdge)
        begin
            syncTgl_q <= !syncTgl_q;
            syncHold_q <= {syncPol, cnt_q};
        end
    end
    logic [34:0] syncR_q; // current sync in result domain
    always_ff @(posedge rclk)
    begin
        if (!rNrst)
        begin
            syncTglR_q <= 3'h0;
            syncR_q <= 35'h0;
        end
        else
        begin
            syncTglR_q <= {syncTglR_q[1:0], syncTgl_q};
            if (syncTglR_q[2] ^ syncTglR_q[1])
                syncR_q <= syncHold_q; // newest sync replaces old
        end
    end
    // free-running frame timer shared by all channels
    logic [5:0] frameCnt_q;
    logic loadPulse;
    logic [5:0] frameLen;
    assign frameLen = len + 6'(`TSRC_FRAME_OVH);
    assign loadPulse = (frameCnt_q == 6'h0);
    always_ff @(posedge rclk)
    begin
        if (!rNrst)
            frameCnt_q <= 6'h0;
        else if (frameCnt_q >= frameLen - 6'h1)
            frameCnt_q <= 6'h0; // runs free, not aligned to events
        else
            frameCnt_q <= frameCnt_q + 6'h1;
    end

    // per channel capture, crossing, pipeline and serialiser
    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++)
        begin : g_ch
            logic edgeOk;
            logic [31:0] gap_q;
            logic tgl_q, pend_q;
            logic [2:0] tglR_q;
            tsrc_stamp_t hold_q;
            // valid edge, retrigger guard
            assign edgeOk = (pinS2_q[ch] ^ pinS3_q[ch]) &&
                            (pinS2_q[ch] != eventPol[ch]) && (gap_q >= TREP);
            always_ff @(posedge core_clk)
            begin
                if (!nrst)
                begin
                    gap_q <= 32'h0;
                    tgl_q <= 1'b0;
                    hold_q <= '0;
                end
                else if (edgeOk)
                begin
                    gap_q <= 32'h1;
                    tgl_q <= !tgl_q;
                    hold_q <= '{stamp: cnt_q, pol: eventPol[ch]};
                end
                else if (gap_q < TREP)
                    gap_q <= gap_q + 32'h1;
            end
            // result domain: waiting stamp, pipeline, shifter
            tsrc_stamp_t buf_q;
            logic [4:0] pipe_q; // five-stage load path
            logic [39:0] res_q, shift_q;
            logic [35:0] diff;
            logic [1:0] calSel;
            logic [39:0] cal;
            tsrc_state_t st_q;
            logic [5:0] bit_q;
            assign calSel = {syncR_q[34], buf_q.pol};
            assign cal = calValues[(ch*4+calSel)*40 +: 40];
            assign diff = {2'b0, buf_q.stamp} - {2'b0, syncR_q[33:0]};
            always_ff @(posedge rclk)
            begin
                if (!rNrst)
                begin
                    tglR_q <= 3'h0;
                    pend_q <= 1'b0;
                    buf_q <= '0;
                    pipe_q <= 5'h0;
                    res_q <= 40'h0;
                end
                else
                begin
                    tglR_q <= {tglR_q[1:0], tgl_q};
                    if (tglR_q[2] ^ tglR_q[1])
                    begin
                        buf_q <= hold_q;
                        pend_q <= 1'b1;
                    end
                    else if (loadPulse && pend_q)
                        pend_q <= 1'b0;
                    pipe_q <= {pipe_q[3:0], loadPulse && pend_q};
                    if (loadPulse && pend_q)
                        res_q <= {{4{diff[35]}}, diff} - cal;
                end
            end
            // serialiser: strobe low, tag, lsb first, two high
            always_ff @(posedge rclk)
            begin
                if (!rNrst)
                begin
                    st_q <= TSRC_S_IDLE;
                    bit_q <= 6'h0;
                    shift_q <= 40'h0;
                    rStrobe[ch] <= 1'b1;
                    rData[ch] <= 1'b0;
                end
                else
                begin
                    case (st_q)
                        TSRC_S_IDLE:
                        begin
                            rStrobe[ch] <= 1'b1;
                            rData[ch] <= 1'b0;
                            if (pipe_q[4])
                            begin
                                shift_q <= res_q;
                                rStrobe[ch] <= 1'b0;
                                rData[ch] <= 1'b1; // tag bit
                                bit_q <= 6'h0;
                                st_q <= TSRC_S_SHIFT;
                            end
                        end
                        TSRC_S_SHIFT:
                        begin
                            rData[ch] <= (bit_q == len - 6'h1) ?
                                         shift_q[39] : shift_q[bit_q];
                            bit_q <= bit_q + 6'h1;
                            if (bit_q == len - 6'h1)
                            begin
                                bit_q <= 6'h0;
                                st_q <= TSRC_S_HIGH;
                            end
                        end
                        TSRC_S_HIGH:
                        begin
                            rStrobe[ch] <= 1'b1;
                            rData[ch] <= 1'b0;
                            bit_q <= bit_q + 6'h1;
                            if (bit_q == 6'h1)
                                st_q <= TSRC_S_IDLE;
                        end
                        default:
                            st_q <= TSRC_S_IDLE;
                    endcase
                end
            end
        end
    endgenerate
endmodule // tsrc_core

// ---- tsrc_core_checker.sv ----
`timescale 1ns/100ps
module tsrc_core_checker
    import tsrc_pkg::*;
#(
    parameter int NCH = 4,
    parameter int TREP = 1
)(
    input wire logic core_clk, // counter clock
    input wire logic nrst, // core reset, low
    input wire logic rclk, // result clock
    input wire logic rNrst, // result reset, low
    input wire logic [2:0] resultLength, // length code
    input wire logic [7:0] dieTemp, // die temperature
    input wire logic thermal_monitor_enable, // monitor on
    input wire logic thermal_alarm_clear, // flag clear
    input wire logic thermal_alarm_flag, // sticky flag
    input wire logic thermal_alarm_pin_o, // pin value
    input wire logic thermal_alarm_pin_oe_n, // pin pulled when low
    input wire logic powerDown, // power down
    input wire logic [NCH-1:0] rStrobe // strobes
);
    logic [5:0] lowCnt_q; // low cycles of strobe 0
    logic [3:0] clrHist_q; // recent clear samples
    wire [5:0] expLow = (resultLength > 3'h4) ? 6'h29 :
        6'h09 + {resultLength, 3'h0}; // tag plus result bits
    wire hot = dieTemp >= 8'h8D; // at or above trip point
    // count strobe-low cycles on channel 0
    always_ff @(posedge rclk)
    begin
        lowCnt_q <= (!rNrst || rStrobe[0]) ? 6'h00 : lowCnt_q + 6'h01;
    end
    // keep the last four clear samples
    always_ff @(posedge core_clk)
    begin
        clrHist_q <= nrst ? {clrHist_q[2:0], thermal_alarm_clear} : 4'h0;
    end
    a_pd_tracks_flag:
    assert property (@(posedge core_clk) disable iff (!nrst)
        powerDown == thermal_alarm_flag) else $error("power down off flag");
    a_pin_trips_hot:
    assert property (@(posedge core_clk) disable iff (!nrst)
        (hot && thermal_monitor_enable)[*5] |-> !thermal_alarm_pin_oe_n)
        else $error("alarm pin not pulled");
    a_pin_quiet_cool:
    assert property (@(posedge core_clk) disable iff (!nrst)
        (!hot)[*5] |-> thermal_alarm_pin_oe_n) else $error("pin pulled cool");
    a_pin_off_disabled:
    assert property (@(posedge core_clk) disable iff (!nrst)
        (!thermal_monitor_enable)[*5] |-> thermal_alarm_pin_oe_n)
        else $error("pin pulled while disabled");
    a_pin_drive_low:
    assert property (@(posedge core_clk) disable iff (!nrst)
        !thermal_alarm_pin_o) else $error("pin value not low");
    a_flag_sets:
    assert property (@(posedge core_clk) disable iff (!nrst)
        !thermal_alarm_pin_oe_n |-> ##[0:3] thermal_alarm_flag)
        else $error("flag not set by alarm");
    a_flag_needs_clear:
    assert property (@(posedge core_clk) disable iff (!nrst)
        $fell(thermal_alarm_flag) |-> |clrHist_q)
        else $error("flag dropped without clear");
    a_strobe_two_high:
    assert property (@(posedge rclk) disable iff (!rNrst)
        (~$past(rStrobe, 2) & $past(rStrobe) & ~rStrobe) == '0)
        else $error("strobe high for one cycle");
    a_frame_length:
    assert property (@(posedge rclk) disable iff (!rNrst)
        $rose(rStrobe[0]) |-> lowCnt_q == expLow)
        else $error("strobe low length wrong");
endmodule // tsrc_core_checker
bind tsrc_core tsrc_core_checker #(.NCH(NCH), .TREP(TREP)) u_chk (
    .core_clk, .nrst, .rclk, .rNrst, .resultLength, .dieTemp,
    .thermal_monitor_enable, .thermal_alarm_clear, .thermal_alarm_flag,
    .thermal_alarm_pin_o, .thermal_alarm_pin_oe_n, .powerDown, .rStrobe);

// ---- tsrc_result_rx.sv ----
`timescale 1ns/100ps
module tsrc_result_rx
    import tsrc_pkg::*;
#(
    parameter int NCH = 4
)(
    input wire logic rclk, // result clock
    input wire logic rNrst, // result reset, low
    input wire logic [NCH-1:0] rStrobe, // strobe per channel
    input wire logic [NCH-1:0] rData, // data per channel
    output logic [NCH-1:0] rxPulse, // word complete
    output logic [39:0] rxWord [NCH] // sign-extended word
);
    logic [39:0] acc [NCH]; // bits gathered so far
    int cnt [NCH]; // bits seen, tag included
    // take tag, then bits lsb first, sign last; extend it
    always_ff @(posedge rclk)
    begin
        for (int c = 0; c < NCH; c++)
        begin
            rxPulse[c] <= 1'b0;
            if (!rNrst)
                cnt[c] <= 0;
            else if (!rStrobe[c])
            begin
                if (cnt[c] > 0)
                    acc[c][cnt[c]-1] <= rData[c];
                cnt[c] <= cnt[c] + 1;
            end
            else if (cnt[c] > 1)
            begin
                rxPulse[c] <= 1'b1;
                for (int b = 0; b < 40; b++)
                    rxWord[c][b] <= acc[c][(b < cnt[c]-1) ? b : cnt[c]-2];
                cnt[c] <= 0;
            end
        end
    end
endmodule // tsrc_result_rx

// ---- tsrc_core_tb_top.sv ----
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
    $display("mismatch at %0t: got %h want %h", $time, g, e); end end
module tsrc_core_tb_top
    import tsrc_pkg::*;
;
    logic core_clk = 1'b0, rclk = 1'b0, nrst = 1'b0, rNrst = 1'b0;
    logic syncIn = 1'b0, syncPol = 1'b0, almClr = 1'b0, monEn = 1'b1;
    logic [3:0] eventIn = 4'h0, eventPol = 4'h0, rStrobe, rData, rxPulse;
    logic [1:0] coarseRangeSel = 2'h1;
    logic [2:0] resultLength = 3'h4;
    logic [7:0] dieTemp = 8'h19;
    logic [39:0] cal [16] = '{default: 40'h0};
    logic [639:0] calValues;
    logic [39:0] rxWord [4];
    logic almFlag, pinO, pinOen, powerDown;
    int errors = 0, checks = 0, seed = 50;
    always #4 core_clk = ~core_clk;
    initial
    begin
        #3;
        forever #16 rclk = ~rclk;
    end
    always_comb
        for (int i = 0; i < 16; i++)
            calValues[i*40 +: 40] = cal[i];
    tsrc_core #(.NCH(4), .TREP(4)) dut (.core_clk, .nrst, .rclk, .rNrst,
        .syncIn, .syncPol, .eventIn, .eventPol, .coarseRangeSel,
        .resultLength, .calValues, .dieTemp, .powerDown, .rStrobe, .rData,
        .thermal_monitor_enable(monEn), .thermal_alarm_clear(almClr),
        .thermal_alarm_flag(almFlag), .thermal_alarm_pin_o(pinO),
        .thermal_alarm_pin_oe_n(pinOen));
    tsrc_result_rx #(.NCH(4)) rx (.rclk, .rNrst, .rStrobe, .rData,
        .rxPulse, .rxWord);
    task automatic tick(input int k);
        repeat (k) @(negedge core_clk);
    endtask
    task automatic test_done;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // keep nb-1 low bits, fill the rest from the sign
    function automatic logic [39:0] sext(input logic [39:0] v, int nb);
        for (int b = nb - 1; b < 39; b++)
            v[b] = v[39];
        return v;
    endfunction
    // sync edge then event edge dt cycles later (event first if dt < 0)
    task automatic measure(input int ch, sp, ep, dt, len, rep);
        logic [39:0] want;
        int nb;
        int n;
        tick(1);
        nb = (len > 4) ? 40 : 8 * (len + 1);
        resultLength = 3'(len);
        syncPol = sp[0];
        eventPol[ch] = ep[0];
        syncIn = sp[0];
        eventIn[ch] = ep[0];
        want = (coarseRangeSel == 2'h0) ? 40'h0 : 40'(dt);
        want = sext(want - cal[ch * 4 + sp * 2 + ep], nb);
        tick(8);
        if (dt >= 0)
            syncIn = ~sp[0];
        else
            eventIn[ch] = ~ep[0];
        tick(dt < 0 ? -dt : dt);
        syncIn = ~sp[0];
        eventIn[ch] = ~ep[0];
        if (rep)
        begin
            tick(1);
            eventIn[ch] = ep[0];
            tick(1);
            eventIn[ch] = ~ep[0];
        end
        n = 0;
        while (rxPulse[ch] !== 1'b1 && n < 200)
        begin
            @(negedge rclk);
            n++;
        end
        `CHK(rxWord[ch], want)
        `CHK(n <= 2 * nb + 20, 1'b1)
        `CHK(n >= nb + 6, 1'b1)
        if (n >= 200)
            test_done();
    endtask
    initial
    begin
        tick(3);
        nrst = 1'b1;
        tick(9);
        rNrst = 1'b1;
        for (int p = 0; p < 4; p++)
        begin
            cal[p] = 40'(7 * p + 3);
            measure(0, p / 2, p % 2, 30, 4, 0);
        end
        for (int l = 0; l < 8; l++)
            measure(1, 0, 1, 200, l, 0);
        measure(2, 0, 0, 40, 4, 1);
        measure(3, 1, 0, -2, 4, 0);
        `CHK(rxWord[3] + 40'd100, 40'd98)
        coarseRangeSel = 2'h0;
        measure(1, 0, 0, 30, 4, 0);
        coarseRangeSel = 2'h2;
        measure(0, 1, 1, 25, 2, 0);
        coarseRangeSel = 2'h3;
        dieTemp = 8'h8C;
        tick(8);
        `CHK({pinOen, almFlag}, 2'b10)
        dieTemp = 8'h8D;
        almClr = 1'b1;
        tick(8);
        `CHK({pinOen, almFlag, powerDown}, 3'b011)
        measure(2, 1, 1, 50, 3, 0);
        dieTemp = 8'h19;
        almClr = 1'b0;
        tick(8);
        `CHK(almFlag, 1'b1)
        almClr = 1'b1;
        tick(8);
        almClr = 1'b0;
        `CHK(almFlag, 1'b0)
        monEn = 1'b0;
        dieTemp = 8'h96;
        tick(8);
        `CHK({pinOen, almFlag}, 2'b10)
        monEn = 1'b1;
        dieTemp = 8'h19;
        repeat (12)
        begin
            cal[$unsigned($random(seed)) % 16] = 40'($random(seed) % 64);
            measure($unsigned($random(seed)) % 4, $random(seed) & 1,
                $random(seed) & 1, 2 + $unsigned($random(seed)) % 300,
                $unsigned($random(seed)) % 8, 0);
        end
        test_done();
    end
endmodule // tsrc_core_tb_top
